/* File: shared/voice_rx_pkg.sv */
// Constants for the voice receive FIFO control block.
// Assumes a 32-bit APB slave with word-aligned registers at four times the index.
package voice_rx_pkg;

	// register indices; byte address is index times four
	localparam logic [13:0] IDX_DATA     = 14'h2760;
	localparam logic [13:0] IDX_SILENCE  = 14'h2761;
	localparam logic [13:0] IDX_CONTROL  = 14'h2762;
	localparam logic [13:0] IDX_RD_PTR   = 14'h2763;
	localparam logic [13:0] IDX_WR_PTR   = 14'h2764;
	localparam logic [13:0] IDX_DMA_LEN  = 14'h2765;
	localparam logic [13:0] IDX_STATUS   = 14'h276A;
	localparam logic [13:0] IDX_IRQ_MASK = 14'h2772;
	localparam logic [13:0] IDX_IRQ_STS  = 14'h2775;

	// control register fields
	localparam int CTL_FILL    = 0;
	localparam int CTL_PTR_CLR = 1;
	localparam int CTL_SILENCE = 2;
	localparam int CTL_DMA_GO  = 3;

	// status register fields
	localparam int STS_POP  = 2;
	localparam int STS_PUSH = 3;
	localparam int STS_FILL = 4;

	// interrupt status and mask fields
	localparam int IRQ_DMA_DONE  = 0;
	localparam int IRQ_OVERFLOW  = 1;
	localparam int IRQ_UNDERFLOW = 2;
	localparam int IRQ_BITS      = 3;

	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam int FIFO_DEPTH = 128;
	localparam int PTR_BITS   = 8;

	typedef enum logic [1:0] {
		DMA_IDLE,
		DMA_FETCH,
		DMA_PUSH
	} dma_state_t;

endpackage

/* File: verilog/voice_rx_fifo_dma_ctrl.sv */
// Voice receive FIFO with software port, silence fill and receive DMA.
// Assumes one clock, APB master, MAC source with valid/ready, decoder pop pulses.
//
// Register access over APB is this design's own decision.
`timescale 1ns/1ps

module voice_rx_fifo_dma_ctrl #(
	parameter int DEPTH = voice_rx_pkg::FIFO_DEPTH
) (
	input  wire logic        ref_clk,
	input  wire logic        arst_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [15:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        src_valid,
	input  wire logic [7:0]  src_data,
	output logic             src_ready,
	input  wire logic        dec_req,
	output logic [7:0]       dec_data,
	output logic             dec_valid,
	output logic             irq
);

	localparam int AW = voice_rx_pkg::PTR_BITS - 1;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic ptr_full(input logic [7:0] w, input logic [7:0] r);
		ptr_full = (w[AW] != r[AW]) && (w[AW-1:0] == r[AW-1:0]);
	endfunction

	function automatic logic [7:0] ptr_inc(input logic [7:0] p);
		ptr_inc = p + 8'h01;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	logic [7:0]              mem [DEPTH];
	logic [7:0]              rd_ptr_r;
	logic [7:0]              wr_ptr_r;
	logic [7:0]              silence_r;
	logic                    sel_silence_r;
	logic [7:0]              dma_len_r;
	logic [7:0]              dma_rem_r;
	logic [7:0]              dma_hold_r;
	voice_rx_pkg::dma_state_t dma_state_r;
	logic                    fill_busy_r;
	logic [AW-1:0]           fill_idx_r;
	logic                    push_act_r;
	logic                    pop_act_r;
	logic [2:0]              irq_sts_r;
	logic [2:0]              irq_sts_nxt;
	logic [2:0]              irq_mask_r;

	////////////////////////////////////////////////////////////////////////////
	// bus decode

	logic [13:0] idx;
	logic        mapped;
	logic        acc;
	logic        go;
	logic        wr;
	logic        rd;
	logic        full;
	logic        empty;
	logic        dma_push;
	logic        sw_push;
	logic        sw_pop;
	logic        dec_pop;
	logic        push;
	logic [7:0]  push_data;
	logic        ovf_ev;
	logic        udf_ev;
	logic        done_ev;
	logic        dma_start;
	logic        ptr_clr;
	logic        fill_start;
	logic [7:0]  head;

	assign idx    = paddr[15:2];
	assign mapped = (paddr[1:0] == 2'b00) &&
		(idx == voice_rx_pkg::IDX_DATA || idx == voice_rx_pkg::IDX_SILENCE ||
		 idx == voice_rx_pkg::IDX_CONTROL || idx == voice_rx_pkg::IDX_RD_PTR ||
		 idx == voice_rx_pkg::IDX_WR_PTR || idx == voice_rx_pkg::IDX_DMA_LEN ||
		 idx == voice_rx_pkg::IDX_STATUS || idx == voice_rx_pkg::IDX_IRQ_MASK ||
		 idx == voice_rx_pkg::IDX_IRQ_STS);

	// a DMA push or decoder pop owns the FIFO this cycle, so the bus waits
	assign acc = psel && penable && !pready;
	assign go  = acc && !dma_push && !dec_req;
	assign wr  = go && pwrite && mapped;
	assign rd  = go && !pwrite && mapped;

	assign full  = ptr_full(wr_ptr_r, rd_ptr_r);
	assign empty = (wr_ptr_r == rd_ptr_r);
	assign head  = sel_silence_r ? silence_r : mem[rd_ptr_r[AW-1:0]];

	assign dma_start  = wr && idx == voice_rx_pkg::IDX_CONTROL &&
		pwdata[voice_rx_pkg::CTL_DMA_GO];
	assign ptr_clr    = wr && idx == voice_rx_pkg::IDX_CONTROL &&
		pwdata[voice_rx_pkg::CTL_PTR_CLR];
	assign fill_start = wr && idx == voice_rx_pkg::IDX_CONTROL &&
		pwdata[voice_rx_pkg::CTL_FILL] && !fill_busy_r;

	////////////////////////////////////////////////////////////////////////////
	// push and pop arbitration

	assign dma_push = (dma_state_r == voice_rx_pkg::DMA_PUSH) && !full && !fill_busy_r;
	assign sw_push  = wr && idx == voice_rx_pkg::IDX_DATA && !fill_busy_r;
	assign sw_pop   = rd && idx == voice_rx_pkg::IDX_DATA && !sel_silence_r &&
		!fill_busy_r;
	assign dec_pop  = dec_req && !sel_silence_r && !fill_busy_r;

	// software pushes on a full FIFO are dropped; DMA simply waits instead
	assign push      = dma_push || (sw_push && !full);
	assign push_data = dma_push ? dma_hold_r : pwdata[7:0];
	assign ovf_ev    = sw_push && full;
	assign udf_ev    = (sw_pop || dec_pop) && empty;
	assign done_ev   = (dma_push && dma_rem_r == 8'h01) ||
		(dma_start && dma_state_r == voice_rx_pkg::DMA_IDLE && dma_len_r == 8'h00);

	////////////////////////////////////////////////////////////////////////////
	// storage

	always_ff @(posedge ref_clk)
	begin
		if (fill_busy_r)
		begin
			mem[fill_idx_r] <= silence_r;
		end
		else if (push)
		begin
			mem[wr_ptr_r[AW-1:0]] <= push_data;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// pointers

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			rd_ptr_r <= 8'h00;
			wr_ptr_r <= 8'h00;
		end
		else if (ptr_clr)
		begin
			rd_ptr_r <= 8'h00;
			wr_ptr_r <= 8'h00;
		end
		else if (wr && idx == voice_rx_pkg::IDX_RD_PTR)
		begin
			rd_ptr_r <= pwdata[7:0];
		end
		else if (wr && idx == voice_rx_pkg::IDX_WR_PTR)
		begin
			wr_ptr_r <= pwdata[7:0];
		end
		else
		begin
			if (push)
			begin
				wr_ptr_r <= ptr_inc(wr_ptr_r);
			end
			if ((sw_pop || dec_pop) && !empty)
			begin
				rd_ptr_r <= ptr_inc(rd_ptr_r);
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// configuration registers

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			silence_r     <= voice_rx_pkg::BYTE_RESET;
			sel_silence_r <= 1'b0;
			dma_len_r     <= voice_rx_pkg::BYTE_RESET;
			irq_mask_r    <= 3'h0;
		end
		else if (wr)
		begin
			if (idx == voice_rx_pkg::IDX_SILENCE)
			begin
				silence_r <= pwdata[7:0];
			end
			if (idx == voice_rx_pkg::IDX_CONTROL)
			begin
				sel_silence_r <= pwdata[voice_rx_pkg::CTL_SILENCE];
			end
			if (idx == voice_rx_pkg::IDX_DMA_LEN)
			begin
				dma_len_r <= pwdata[7:0];
			end
			if (idx == voice_rx_pkg::IDX_IRQ_MASK)
			begin
				irq_mask_r <= pwdata[2:0];
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// silence fill

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			fill_busy_r <= 1'b0;
			fill_idx_r  <= '0;
		end
		else if (fill_start)
		begin
			fill_busy_r <= 1'b1;
			fill_idx_r  <= '0;
		end
		else if (fill_busy_r)
		begin
			fill_idx_r <= fill_idx_r + 1'b1;
			if (fill_idx_r == AW'(DEPTH - 1))
			begin
				fill_busy_r <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// receive DMA

	// one byte per two cycles keeps src_ready a plain flop
	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			dma_state_r <= voice_rx_pkg::DMA_IDLE;
			dma_rem_r   <= 8'h00;
			dma_hold_r  <= 8'h00;
			src_ready   <= 1'b0;
		end
		else
		begin
			unique case (dma_state_r)
				voice_rx_pkg::DMA_IDLE:
				begin
					if (dma_start && dma_len_r != 8'h00)
					begin
						dma_state_r <= voice_rx_pkg::DMA_FETCH;
						dma_rem_r   <= dma_len_r;
						src_ready   <= 1'b1;
					end
				end
				voice_rx_pkg::DMA_FETCH:
				begin
					if (src_valid)
					begin
						dma_hold_r  <= src_data;
						src_ready   <= 1'b0;
						dma_state_r <= voice_rx_pkg::DMA_PUSH;
					end
				end
				voice_rx_pkg::DMA_PUSH:
				begin
					if (dma_push)
					begin
						dma_rem_r <= dma_rem_r - 8'h01;
						if (dma_rem_r == 8'h01)
						begin
							dma_state_r <= voice_rx_pkg::DMA_IDLE;
						end
						else
						begin
							dma_state_r <= voice_rx_pkg::DMA_FETCH;
							src_ready   <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// activity flags and decoder output

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			push_act_r <= 1'b0;
			pop_act_r  <= 1'b0;
			dec_data   <= 8'h00;
			dec_valid  <= 1'b0;
		end
		else
		begin
			push_act_r <= push;
			pop_act_r  <= (sw_pop || dec_pop) && !empty;
			dec_valid  <= dec_req;
			if (dec_req)
			begin
				// underflow and fill both fall back to the silence byte
				dec_data <= (dec_pop && !empty) ? head : silence_r;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// interrupt status, read clears, a set in the same cycle wins

	always_comb
	begin
		irq_sts_nxt = irq_sts_r;
		if (rd && idx == voice_rx_pkg::IDX_IRQ_STS)
		begin
			irq_sts_nxt = 3'h0;
		end
		if (ptr_clr)
		begin
			irq_sts_nxt[voice_rx_pkg::IRQ_OVERFLOW]  = 1'b0;
			irq_sts_nxt[voice_rx_pkg::IRQ_UNDERFLOW] = 1'b0;
		end
		if (done_ev)
		begin
			irq_sts_nxt[voice_rx_pkg::IRQ_DMA_DONE] = 1'b1;
		end
		if (ovf_ev)
		begin
			irq_sts_nxt[voice_rx_pkg::IRQ_OVERFLOW] = 1'b1;
		end
		if (udf_ev)
		begin
			irq_sts_nxt[voice_rx_pkg::IRQ_UNDERFLOW] = 1'b1;
		end
	end

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			irq_sts_r <= 3'h0;
			irq       <= 1'b0;
		end
		else
		begin
			irq_sts_r <= irq_sts_nxt;
			irq       <= |(irq_sts_nxt & irq_mask_r);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// APB answer

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end
		else if (go)
		begin
			pready  <= 1'b1;
			pslverr <= !mapped;
			prdata  <= 32'h0000_0000;
			if (rd)
			begin
				unique case (idx)
					voice_rx_pkg::IDX_DATA:
						prdata[7:0] <= fill_busy_r ? silence_r : head;
					voice_rx_pkg::IDX_SILENCE:
						prdata[7:0] <= silence_r;
					voice_rx_pkg::IDX_CONTROL:
						prdata[voice_rx_pkg::CTL_SILENCE] <= sel_silence_r;
					voice_rx_pkg::IDX_RD_PTR:
						prdata[7:0] <= rd_ptr_r;
					voice_rx_pkg::IDX_WR_PTR:
						prdata[7:0] <= wr_ptr_r;
					voice_rx_pkg::IDX_DMA_LEN:
						prdata[7:0] <= dma_len_r;
					voice_rx_pkg::IDX_STATUS:
					begin
						prdata[voice_rx_pkg::STS_FILL] <= fill_busy_r;
						prdata[voice_rx_pkg::STS_PUSH] <= push_act_r;
						prdata[voice_rx_pkg::STS_POP]  <= pop_act_r;
					end
					voice_rx_pkg::IDX_IRQ_MASK:
						prdata[2:0] <= irq_mask_r;
					default:
						prdata[2:0] <= irq_sts_r;
				endcase
			end
		end
		else
		begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
	end

endmodule

/* File: tb/voice_rx_fifo_dma_ctrl_sva.sv */
// port-level checks of the voice receive fifo block
// assumes the bind at the foot attaches it to every instance
`timescale 1ns/1ps

module voice_rx_chk (
	input wire logic        ref_clk,
	input wire logic        arst_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	input wire logic        src_valid,
	input wire logic        src_ready,
	input wire logic        dec_req,
	input wire logic        dec_valid
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!arst_n);

	sequence s_take;
		src_valid && src_ready;
	endsequence

	sequence s_wait;
		src_ready && !src_valid;
	endsequence

	a_ready_pulse: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	a_ready_cause: assert property (pready |-> $past(psel && penable))
		else $error("pready without access phase");
	a_err_clean: assert property (pslverr |-> pready && prdata == 32'h0000_0000)
		else $error("error answer malformed");
	a_rdata_byte: assert property (pready |-> prdata[31:8] == 24'h00_0000)
		else $error("upper read data not zero");
	a_dec_answer: assert property (dec_req |=> dec_valid)
		else $error("decoder request unanswered");
	a_dec_cause: assert property (dec_valid |-> $past(dec_req))
		else $error("decoder byte without request");
	a_src_take: assert property (s_take |=> !src_ready)
		else $error("source ready kept after take");
	a_src_hold: assert property (s_wait |=> src_ready)
		else $error("source ready dropped before take");
endmodule

////////////////////////////////////////////////////////////////////////////////
bind voice_rx_fifo_dma_ctrl voice_rx_chk chk_u (
	.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .src_valid(src_valid), .src_ready(src_ready),
	.dec_req(dec_req), .dec_valid(dec_valid)
);

/* File: tb/mac_src_model.sv */
// receive mac source: offers counting bytes from 8'h40 on
// assumes the dma side takes a byte on valid and ready at an edge
`timescale 1ns/1ps

module mac_src_model (
	input  wire logic       ref_clk,
	input  wire logic       arst_n,
	input  wire logic       src_ready,
	output logic            src_valid,
	output logic [7:0]      src_data
);
	logic [7:0] cnt_r;
	logic [1:0] gap_r;

	always_ff @(posedge ref_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cnt_r     <= 8'h00;
			gap_r     <= 2'h0;
			src_valid <= 1'b0;
			src_data  <= 8'h00;
		end
		else if (src_valid && src_ready)
		begin
			// released data turns over so a late sample cannot match
			src_valid <= 1'b0;
			src_data  <= ~src_data;
			cnt_r     <= cnt_r + 8'h01;
			gap_r     <= cnt_r[0] ? 2'h3 : 2'h0;
		end
		else if (gap_r != 2'h0)
		begin
			gap_r <= gap_r - 2'h1;
		end
		else if (!src_valid)
		begin
			src_valid <= 1'b1;
			src_data  <= 8'h40 + cnt_r;
		end
	end
endmodule

/* File: tb/voice_rx_fifo_dma_ctrl_tb.sv */
// self-checking bench: apb register traffic, decoder pops, mac source model
// assumes the bound checker and the source model are compiled beforehand
`timescale 1ns/1ps

module voice_rx_fifo_dma_ctrl_tb;
	logic        ref_clk = 0, arst_n = 0, psel = 0, penable = 0, pwrite = 0, dec_req = 0;
	logic [15:0] paddr = 16'h0000;
	logic [31:0] pwdata = 32'h0000_0000, prdata;
	logic        pready, pslverr, src_valid, src_ready, dec_valid, irq, err;
	logic [7:0]  src_data, dec_data;
	logic [31:0] rd_v;
	int          fail_count = 0, n_checks = 0;

	voice_rx_fifo_dma_ctrl dut_u (.ref_clk(ref_clk), .arst_n(arst_n), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .src_valid(src_valid), .src_data(src_data),
		.src_ready(src_ready), .dec_req(dec_req), .dec_data(dec_data),
		.dec_valid(dec_valid), .irq(irq));
	mac_src_model src_u (.ref_clk(ref_clk), .arst_n(arst_n), .src_ready(src_ready),
		.src_valid(src_valid), .src_data(src_data));

	initial
	begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		if (fail_count == 0 && n_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_checks++;
		if (g !== e)
		begin
			fail_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask

	// one transfer; the request holds until pready is sampled high
	task automatic apb(input logic w, input logic [13:0] idx, input logic [7:0] wd);
		int n;
		n = 0;
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= {idx, 2'b00};
		pwdata  <= {24'h00_0000, wd};
		@(posedge ref_clk);
		penable <= 1'b1;
		do
		begin
			@(posedge ref_clk);
			n++;
		end
		while (pready !== 1'b1 && n < 400);
		if (n >= 400)
		begin
			chk("apb wait", 1, 0);
			end_of_test();
		end
		rd_v = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge ref_clk);
	endtask

	task automatic wr(input logic [13:0] idx, input logic [7:0] d);
		apb(1'b1, idx, d);
	endtask

	task automatic rdc(input string nm, input logic [13:0] idx, input logic [7:0] e);
		apb(1'b0, idx, 8'h00);
		chk(nm, {24'h00_0000, e}, rd_v);
	endtask

	task automatic pop(input logic [7:0] e);
		dec_req <= 1'b1;
		@(posedge ref_clk);
		dec_req <= 1'b0;
		@(posedge ref_clk);
		chk("dec_valid", 1, dec_valid);
		chk("dec_data", e, dec_data);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial
	begin
		logic [13:0] rst_idx [6];
		int n;
		rst_idx = '{voice_rx_pkg::IDX_SILENCE, voice_rx_pkg::IDX_CONTROL,
			voice_rx_pkg::IDX_RD_PTR, voice_rx_pkg::IDX_WR_PTR,
			voice_rx_pkg::IDX_STATUS, voice_rx_pkg::IDX_DMA_LEN};
		repeat (20) @(posedge ref_clk);
		arst_n <= 1'b1;
		@(posedge ref_clk);
		foreach (rst_idx[i])
			rdc("reset value", rst_idx[i], 8'h00);
		apb(1'b0, 14'h2766, 8'h00);
		chk("unmapped err", 1, err);
		// fill, then an empty read shows the silence byte and flags underflow
		wr(voice_rx_pkg::IDX_SILENCE, 8'hA5);
		wr(voice_rx_pkg::IDX_CONTROL, 8'h01);
		rdc("fill busy", voice_rx_pkg::IDX_STATUS, 8'h10);
		n = 0;
		do
		begin
			apb(1'b0, voice_rx_pkg::IDX_STATUS, 8'h00);
			n++;
		end
		while (rd_v[4] !== 1'b0 && n < 100);
		chk("fill done", 32'h0000_0000, rd_v);
		if (rd_v[4] !== 1'b0)
			end_of_test();
		rdc("filled byte", voice_rx_pkg::IDX_DATA, 8'hA5);
		chk("irq masked", 0, irq);
		rdc("irq sts", voice_rx_pkg::IDX_IRQ_STS, 8'h04);
		rdc("irq cleared", voice_rx_pkg::IDX_IRQ_STS, 8'h00);
		// software push, read back in order, pointer rewrite
		wr(voice_rx_pkg::IDX_CONTROL, 8'h02);
		rdc("rd ptr clr", voice_rx_pkg::IDX_RD_PTR, 8'h00);
		for (int i = 1; i < 4; i++)
			wr(voice_rx_pkg::IDX_DATA, 8'(i * 8'h11));
		rdc("wr ptr", voice_rx_pkg::IDX_WR_PTR, 8'h03);
		for (int i = 1; i < 4; i++)
			rdc("data port", voice_rx_pkg::IDX_DATA, 8'(i * 8'h11));
		rdc("rd ptr", voice_rx_pkg::IDX_RD_PTR, 8'h03);
		wr(voice_rx_pkg::IDX_RD_PTR, 8'h01);
		rdc("rewound", voice_rx_pkg::IDX_DATA, 8'h22);
		// silence select replaces the fifo byte at the decoder
		wr(voice_rx_pkg::IDX_CONTROL, 8'h04);
		rdc("ctl mute", voice_rx_pkg::IDX_CONTROL, 8'h04);
		rdc("mute port", voice_rx_pkg::IDX_DATA, 8'hA5);
		pop(8'hA5);
		// dma of four bytes with completion interrupt enabled
		wr(voice_rx_pkg::IDX_CONTROL, 8'h02);
		wr(voice_rx_pkg::IDX_DMA_LEN, 8'h04);
		wr(voice_rx_pkg::IDX_IRQ_MASK, 8'h01);
		wr(voice_rx_pkg::IDX_CONTROL, 8'h08);
		// access waits out the second dma push, then sees its flag
		rdc("push flag", voice_rx_pkg::IDX_STATUS, 8'h08);
		n = 0;
		while (irq !== 1'b1 && n < 300)
		begin
			@(posedge ref_clk);
			n++;
		end
		chk("irq raised", 1, irq);
		if (irq !== 1'b1)
			end_of_test();
		rdc("dma done", voice_rx_pkg::IDX_IRQ_STS, 8'h01);
		@(posedge ref_clk);
		chk("irq clear", 0, irq);
		rdc("dma count", voice_rx_pkg::IDX_WR_PTR, 8'h04);
		rdc("start self clr", voice_rx_pkg::IDX_CONTROL, 8'h00);
		// decoder pop stalls a status read by one cycle, which then sees the pop flag
		fork
			apb(1'b0, voice_rx_pkg::IDX_STATUS, 8'h00);
			begin
				@(posedge ref_clk);
				pop(8'h40);
			end
		join
		chk("pop flag", 32'h0000_0004, rd_v);
		for (int i = 1; i < 4; i++)
			pop(8'(8'h40 + i));
		// wrap bit differs, low bits equal: full, so the push is dropped
		wr(voice_rx_pkg::IDX_WR_PTR, 8'h84);
		wr(voice_rx_pkg::IDX_DATA, 8'h77);
		rdc("full drop", voice_rx_pkg::IDX_WR_PTR, 8'h84);
		rdc("overflow", voice_rx_pkg::IDX_IRQ_STS, 8'h02);
		chk("ovf masked", 0, irq);
		wr(voice_rx_pkg::IDX_DATA, 8'h77);
		wr(voice_rx_pkg::IDX_CONTROL, 8'h02);
		rdc("err clr", voice_rx_pkg::IDX_IRQ_STS, 8'h00);
		rdc("wr ptr clr", voice_rx_pkg::IDX_WR_PTR, 8'h00);
		end_of_test();
	end
endmodule
